// file: rtl/sebp_pkg.sv
/*
 * Shared constants of the two-wire serial byte memory pin logic.
 * Assumes a 100 MHz system clock and a serial clock from an external bus master.
 */
package sebp_pkg;

    // ==========================================================================
    // Array organisation
    // ==========================================================================
    // Word width and the two supported array depths.
    localparam int WORD_BITS       = 8;
    localparam int MEM_WORDS_SMALL = 128;
    localparam int MEM_WORDS_LARGE = 256;

    // ==========================================================================
    // Bus addressing
    // ==========================================================================
    // Number of hard-wired select inputs and the devices they can tell apart.
    localparam int SEL_BITS    = 3;
    localparam int MAX_DEVICES = 8;
    // Width of the device-type field that precedes the select bits.
    localparam int TYPE_BITS   = 4;

    // ==========================================================================
    // Bit slots within one nine-clock byte frame
    // ==========================================================================
    // Slots 0..7 carry data MSB first, slot 8 carries the acknowledge.
    localparam logic [3:0] SLOT_FIRST     = 4'h0;
    localparam logic [3:0] SLOT_ADDR_LAST = 4'h6;
    localparam logic [3:0] SLOT_RW        = 4'h7;
    localparam logic [3:0] SLOT_ACK       = 4'h8;
    // Output plans are made two slots ahead of the slot they drive.
    localparam logic [3:0] PLAN_AHEAD     = 4'h2;
    localparam logic [3:0] SLOT_COUNT     = 4'h9;

    // ==========================================================================
    // Synchroniser vector layout
    // ==========================================================================
    localparam int SYN_SEL0  = 0;
    localparam int SYN_WP    = 3;
    localparam int SYN_BIT   = 4;
    localparam int SYN_TGL   = 5;
    localparam int SYN_SDA   = 6;
    localparam int SYN_SCL   = 7;
    localparam int SYN_WIDTH = 8;

    // Protocol states of the transaction engine.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_WADDR,
        ST_WDATA,
        ST_RDATA,
        ST_IGNORE
    } sebp_state_t;

endpackage : sebp_pkg

// file: rtl/sebp_serial_eeprom.sv
/*
 * Two-wire serial byte memory: pin logic, transaction engine and array.
 * Assumes an external bus master drives the serial clock and the wired data
 * line, that the bench resolves the open-drain line from sdaOe, and that
 * undriven select and write-protect pins resolve low at the pad.
 */
// Function
// - Answer only when received select bits match the three select inputs.
// - Distinct select settings let eight devices share one bus individually.
// - Undriven select and write-protect inputs count as logic low.
// - Data line is open drain: pull low or release, never drive high.
// - Command and write-data bits are captured on the serial clock rising edge.
// - Read data and acknowledges change only after a serial clock falling edge.
// - Write-protect high inhibits every array write; low allows normal writes.
// - Array holds 128 or 256 eight-bit words addressed by byte location.
`timescale 1ns/10ps

module sebp_serial_eeprom
    import sebp_pkg::*;
#(
    parameter int              MEM_WORDS   = MEM_WORDS_LARGE,
    parameter logic [3:0]      DEVICE_TYPE = 4'hA
) (
    // System clock domain.
    input  wire logic          sys_clk,
    input  wire logic          arst_n,
    input  wire logic          clkEn,
    // Link clock domain: serial clock from the bus master.
    input  wire logic          sclLink,
    // Open-drain data line.
    input  wire logic          sdaIn,
    output logic               sdaOut,
    output logic               sdaOe,
    // Hard-wired strap pins.
    input  wire logic          selectInputBit0,
    input  wire logic          selectInputBit1,
    input  wire logic          selectInputBit2,
    input  wire logic          writeProtect
);

    // ==========================================================================
    // Elaboration checks
    // ==========================================================================
    localparam int ADDR_W = $clog2(MEM_WORDS);

    // Only the two documented array depths are served.
    generate
        if (MEM_WORDS != MEM_WORDS_SMALL && MEM_WORDS != MEM_WORDS_LARGE) begin : g_badDepth
            $error("MEM_WORDS must be 128 or 256.");
        end
    endgenerate

    // ==========================================================================
    // Declarations
    // ==========================================================================
    // Link-side registers.
    logic                   bitTgl_reg;
    logic                   linkBit_reg;
    logic                   capLow_reg;
    logic                   capGate_reg;
    logic                   sdaOe_reg;
    logic                   sdaOut_reg;

    // System-side synchronisers and edge history.
    logic [SYN_WIDTH-1:0]   syncA_reg;
    logic [SYN_WIDTH-1:0]   syncB_reg;
    logic [SYN_WIDTH-1:0]   syncIn;
    logic                   sdaD_reg;
    logic                   tglD_reg;
    logic                   tglE_reg;

    // Transaction engine state.
    sebp_state_t            state_reg;
    sebp_state_t            state_next;
    logic [3:0]             slot_reg;
    logic [3:0]             slot_next;
    logic [WORD_BITS-1:0]   shift_reg;
    logic [WORD_BITS-1:0]   shift_next;
    logic [WORD_BITS-1:0]   rdByte_reg;
    logic [WORD_BITS-1:0]   rdByte_next;
    logic [ADDR_W-1:0]      ptr_reg;
    logic [ADDR_W-1:0]      ptr_next;
    logic                   match_reg;
    logic                   match_next;
    logic                   read_reg;
    logic                   read_next;
    logic                   planLow_reg;
    logic                   planLow_next;
    logic                   planGate_reg;
    logic                   planGate_next;
    logic                   memWe;

    // Memory array.
    logic [WORD_BITS-1:0]   mem [MEM_WORDS];

    // Decoded events.
    wire logic              sclHigh    = syncB_reg[SYN_SCL];
    wire logic              sdaNow     = syncB_reg[SYN_SDA];
    wire logic              bitData    = syncB_reg[SYN_BIT];
    wire logic              wpLevel    = syncB_reg[SYN_WP];
    wire logic [2:0]        selLevel   = syncB_reg[SYN_SEL0 +: SEL_BITS];
    wire logic              startSeen  = sclHigh & sdaD_reg & ~sdaNow;
    wire logic              stopSeen   = sclHigh & ~sdaD_reg & sdaNow;
    wire logic              bitSeen    = tglD_reg ^ tglE_reg;
    wire logic [WORD_BITS-1:0] nextWord = mem[ptr_reg];
    wire logic [6:0]        rxAddr     = {shift_reg[5:0], bitData};
    wire logic [6:0]        myAddr     = {DEVICE_TYPE, selLevel};
    wire logic [3:0]        slotPlus   = 4'(slot_reg + PLAN_AHEAD);

    // Bit of a byte that travels in a given slot, MSB in slot 0.
    function automatic logic bitOf(input logic [WORD_BITS-1:0] b, input logic [3:0] s);
        logic [2:0] idx;
        idx   = 3'(4'h7 - s);
        bitOf = b[idx];
    endfunction

    // ==========================================================================
    // Link clock domain
    // ==========================================================================
    // Rising edge: take the data bit and announce it with a toggle.
    // rising edge capture
    always_ff @(posedge sclLink or negedge arst_n) begin
        if (!arst_n) begin
            bitTgl_reg  <= 1'b0;
            linkBit_reg <= 1'b0;
            capLow_reg  <= 1'b0;
            capGate_reg <= 1'b0;
        end else begin
            bitTgl_reg  <= ~bitTgl_reg;
            linkBit_reg <= sdaIn;
            capLow_reg  <= planLow_reg;   // First stage of the plan crossing.
            capGate_reg <= planGate_reg;
        end
    end

    // Falling edge: second plan stage drives the line; a read byte is only
    // started when the master acknowledged the previous one.
    // falling edge update
    always_ff @(negedge sclLink or negedge arst_n) begin
        if (!arst_n) begin
            sdaOe_reg  <= 1'b0;
            sdaOut_reg <= 1'b0;
        end else begin
            sdaOe_reg  <= capLow_reg & ~(capGate_reg & linkBit_reg);
            sdaOut_reg <= 1'b0;
        end
    end

    assign sdaOe  = sdaOe_reg;
    assign sdaOut = sdaOut_reg;

    // ==========================================================================
    // System clock domain: synchronisers
    // ==========================================================================
    // Pins and link-side signals gathered for two-flop synchronisation.
    // pad pull-down low
    assign syncIn = {sclLink, sdaIn, bitTgl_reg, linkBit_reg, writeProtect,
                     selectInputBit2, selectInputBit1, selectInputBit0};

    // Two flops per signal, then the edge history used by the detectors.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            // Idle bus levels, so that leaving reset shows no false stop.
            syncA_reg <= 8'hC0;
            syncB_reg <= 8'hC0;
            sdaD_reg  <= 1'b1;
            tglD_reg  <= 1'b0;
            tglE_reg  <= 1'b0;
        end else if (clkEn) begin
            syncA_reg <= syncIn;
            syncB_reg <= syncA_reg;
            sdaD_reg  <= sdaNow;
            tglD_reg  <= syncB_reg[SYN_TGL];
            tglE_reg  <= tglD_reg;
        end
    end

    // ==========================================================================
    // System clock domain: transaction engine
    // ==========================================================================
    // Next-state logic; output plans are made two slots ahead.
    always_comb begin
        state_next    = state_reg;
        slot_next     = slot_reg;
        shift_next    = shift_reg;
        rdByte_next   = rdByte_reg;
        ptr_next      = ptr_reg;
        match_next    = match_reg;
        read_next     = read_reg;
        planLow_next  = planLow_reg;
        planGate_next = planGate_reg;
        memWe         = 1'b0;
        if (startSeen) begin
            state_next    = ST_ADDR;
            slot_next     = SLOT_FIRST;
            match_next    = 1'b0;
            planLow_next  = 1'b0;
            planGate_next = 1'b0;
        end else if (stopSeen) begin
            state_next    = ST_IDLE;
            planLow_next  = 1'b0;
            planGate_next = 1'b0;
        end else if (bitSeen) begin
            slot_next     = (slot_reg == SLOT_ACK) ? SLOT_FIRST : 4'(slot_reg + 4'h1);
            planLow_next  = 1'b0;
            planGate_next = 1'b0;
            if (slot_reg != SLOT_ACK) begin
                shift_next = {shift_reg[6:0], bitData};
            end
            case (state_reg)
                ST_ADDR: begin
                    if (slot_reg == SLOT_ADDR_LAST) begin
                        match_next   = (rxAddr == myAddr);
                        planLow_next = (rxAddr == myAddr);
                    end else if (slot_reg == SLOT_RW) begin
                        read_next = bitData;
                        if (match_reg && bitData) begin
                            planLow_next  = ~bitOf(nextWord, SLOT_FIRST);
                            planGate_next = 1'b1;
                        end
                    end else if (slot_reg == SLOT_ACK) begin
                        if (!match_reg) begin
                            state_next = ST_IGNORE;
                        end else if (read_reg) begin
                            state_next   = ST_RDATA;
                            rdByte_next  = nextWord;
                            ptr_next     = ADDR_W'(ptr_reg + 1'b1);
                            planLow_next = ~bitOf(nextWord, 4'h1);
                        end else begin
                            state_next = ST_WADDR;
                        end
                    end
                end
                ST_WADDR: begin
                    if (slot_reg == SLOT_ADDR_LAST) begin
                        planLow_next = 1'b1;
                    end else if (slot_reg == SLOT_ACK) begin
                        ptr_next   = shift_reg[ADDR_W-1:0];
                        state_next = ST_WDATA;
                    end
                end
                ST_WDATA: begin
                    if (slot_reg == SLOT_ADDR_LAST) begin
                        planLow_next = 1'b1;
                    end else if (slot_reg == SLOT_ACK) begin
                        memWe    = ~wpLevel;
                        ptr_next = ADDR_W'(ptr_reg + 1'b1);
                    end
                end
                ST_RDATA: begin
                    if (slot_reg < SLOT_ADDR_LAST) begin
                        planLow_next = ~bitOf(rdByte_reg, slotPlus);
                    end else if (slot_reg == SLOT_RW) begin
                        planLow_next  = ~bitOf(nextWord, SLOT_FIRST);
                        planGate_next = 1'b1;
                    end else if (slot_reg == SLOT_ACK) begin
                        if (bitData) begin
                            state_next = ST_IGNORE;
                        end else begin
                            rdByte_next  = nextWord;
                            ptr_next     = ADDR_W'(ptr_reg + 1'b1);
                            planLow_next = ~bitOf(nextWord, 4'h1);
                        end
                    end
                end
                default: begin
                    planLow_next = 1'b0;
                end
            endcase
        end
    end

    // Engine registers; everything holds while the clock enable is low.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg    <= ST_IDLE;
            slot_reg     <= SLOT_FIRST;
            shift_reg    <= 8'h00;
            rdByte_reg   <= 8'h00;
            ptr_reg      <= '0;
            match_reg    <= 1'b0;
            read_reg     <= 1'b0;
            planLow_reg  <= 1'b0;
            planGate_reg <= 1'b0;
        end else if (clkEn) begin
            state_reg    <= state_next;
            slot_reg     <= slot_next;
            shift_reg    <= shift_next;
            rdByte_reg   <= rdByte_next;
            ptr_reg      <= ptr_next;
            match_reg    <= match_next;
            read_reg     <= read_next;
            planLow_reg  <= planLow_next;
            planGate_reg <= planGate_next;
        end
    end

    // ==========================================================================
    // Memory array
    // ==========================================================================
    // Array write port; contents are not cleared by reset.
    // array storage
    always_ff @(posedge sys_clk) begin
        if (clkEn && memWe) begin
            mem[ptr_reg] <= shift_reg;
        end
    end

endmodule // sebp_serial_eeprom

// file: test/sebp_bus_master.sv
/*
 * Behavioural two-wire bus master driving the serial clock and data pull.
 * Assumes a pull-up on the data line, resolved by the bench into sdaLine.
 */
`timescale 1ns/10ps
module sebp_bus_master (
    // Serial clock and data-line pull.
    output logic      sclLink,
    output logic      sdaLow,
    // Resolved data-line level.
    input  wire logic sdaLine
);
    // ==========================================================================
    // Bus phases
    // ==========================================================================
    // Idle clock high.
    initial begin
        sclLink = 1'b1;
        sdaLow  = 1'b0;
    end

    // One 125 ns clock slot: data set mid low phase, sampled mid high phase.
    task automatic bit_cycle(input logic b, output logic s);
        #31.25 sdaLow = ~b;
        #31.25 sclLink = 1'b1;
        #31.25 s = sdaLine;
        #31.25 sclLink = 1'b0;
    endtask

    // Start or repeated start; the odd 0.3 ns keeps edges off sys_clk edges.
    task automatic start_cond();
        #31.55 sdaLow = 1'b0;
        #31.25 sclLink = 1'b1;
        #31.25 sdaLow = 1'b1;
        #31.25 sclLink = 1'b0;
    endtask

    // Stop leaves clock high, then one slot of bus free time.
    task automatic stop_cond();
        #31.25 sdaLow = 1'b1;
        #31.25 sclLink = 1'b1;
        #31.25 sdaLow = 1'b0;
        #125;
    endtask

    // Byte out MSB first; ack is high when the device pulled the ninth slot.
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(d[i], s);
        end
        bit_cycle(1'b1, s);
        ack = ~s;
    endtask

    // Byte in MSB first, then the master's ack or nack.
    task automatic recv_byte(input logic mAck, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, d[i]);
        end
        bit_cycle(~mAck, s);
    endtask
endmodule // sebp_bus_master

// file: test/sebp_properties.sv
/*
 * Checker of data-line timing for the serial byte memory pin logic.
 * Assumes it is bound to sebp_serial_eeprom with a 100 MHz sys_clk and a
 * serial clock whose high phase lasts about 62.5 ns.
 */
`timescale 1ns/10ps
module sebp_properties
    import sebp_pkg::*;
#(
    parameter int         MEM_WORDS   = MEM_WORDS_LARGE,
    parameter logic [3:0] DEVICE_TYPE = 4'hA
) (
    // System side.
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    // Link side.
    input wire logic sclLink,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    // Straps.
    input wire logic selectInputBit0,
    input wire logic selectInputBit1,
    input wire logic selectInputBit2,
    input wire logic writeProtect
);
    // ==========================================================================
    // Data-line checks
    // ==========================================================================
    // All checks run on the system clock and rest while reset is low.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    AST_NEVER_DRIVES_HIGH: assert property (sdaOut == 1'b0)
        else $error("data line driven high");
    AST_QUIET_AFTER_RESET: assert property ($rose(arst_n) |-> !sdaOe [*4])
        else $error("data line pulled right after reset");
    AST_MOVES_AFTER_FALL: assert property ($changed(sdaOe) |-> !sclLink && $past(sclLink))
        else $error("data output changed away from a clock fall");
    AST_STEADY_AFTER_RISE: assert property ($rose(sclLink) |=> $stable(sdaOe) [*5])
        else $error("data output moved while clock high");
    AST_OFF_WHILE_IDLE: assert property (sclLink [*8] |-> !sdaOe)
        else $error("data line pulled while bus idle");
    AST_NO_FALSE_START: assert property (sclLink && $fell(sdaIn) |-> !sdaOe)
        else $error("device pulled line low while clock high");
endmodule // sebp_properties

bind sebp_serial_eeprom sebp_properties #(
    .MEM_WORDS(MEM_WORDS),
    .DEVICE_TYPE(DEVICE_TYPE)
) u_sebp_properties (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .sclLink(sclLink),
    .sdaIn(sdaIn),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .selectInputBit0(selectInputBit0),
    .selectInputBit1(selectInputBit1),
    .selectInputBit2(selectInputBit2),
    .writeProtect(writeProtect)
);

// file: test/test_sebp_serial_eeprom.sv
/*
 * Self-checking bench for the serial byte memory pin logic.
 * Assumes the bus master model and a pull-up plus pull-down pads in here.
 */
`timescale 1ns/10ps
module test_sebp_serial_eeprom
    import sebp_pkg::*;
;
    localparam logic [3:0] DEV_TYPE = 4'hA; // Arbitrary type code.
    logic       sys_clk = 1'b0;
    logic       arst_n;
    logic       clkEnDrv;
    logic       sclLink;
    logic       sdaLow;
    logic       sdaOut;
    logic       sdaOe;
    logic [2:0] selDrv;
    logic       wpDrv;
    tri0  [2:0] selPad;
    tri0        wpPad;
    wire        sdaLine;
    int         bad_count = 0;
    int         total_checks = 0;

    // Pads: pull-downs on straps, pull-up on the data line.
    assign selPad  = selDrv;
    assign wpPad   = wpDrv;
    assign sdaLine = ~(sdaLow | sdaOe);
    always #5 sys_clk = ~sys_clk;

    sebp_serial_eeprom #(
        .MEM_WORDS(MEM_WORDS_LARGE),
        .DEVICE_TYPE(DEV_TYPE)
    ) u_sebp_serial_eeprom (
        .sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEnDrv), .sclLink(sclLink),
        .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .selectInputBit0(selPad[0]),
        .selectInputBit1(selPad[1]), .selectInputBit2(selPad[2]), .writeProtect(wpPad));
    sebp_bus_master u_sebp_bus_master (.sclLink(sclLink), .sdaLow(sdaLow), .sdaLine(sdaLine));

    // ==========================================================================
    // Compare and transfer tasks
    // ==========================================================================
    task automatic check_bit(input logic got, input logic exp, input string what);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: %s got %b", $time, what, got);
        end
    endtask

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // Addressed write of two bytes; every byte must be acknowledged.
    task automatic write_pair(input logic [2:0] sel, input logic [7:0] wa, d0, d1);
        logic [7:0] b [4];
        logic       a;
        b = '{{DEV_TYPE, sel, 1'b0}, wa, d0, d1};
        u_sebp_bus_master.start_cond();
        foreach (b[i]) begin
            u_sebp_bus_master.send_byte(b[i], a);
            check_bit(a, 1'b1, "write ack");
        end
        u_sebp_bus_master.stop_cond();
    endtask

    // Random read of two sequential bytes ending with a nack.
    task automatic read_pair(input logic [2:0] sel, input logic [7:0] wa, e0, e1);
        logic [7:0] d;
        logic       a;
        u_sebp_bus_master.start_cond();
        u_sebp_bus_master.send_byte({DEV_TYPE, sel, 1'b0}, a);
        check_bit(a, 1'b1, "address ack");
        u_sebp_bus_master.send_byte(wa, a);
        check_bit(a, 1'b1, "word address ack");
        u_sebp_bus_master.start_cond();
        u_sebp_bus_master.send_byte({DEV_TYPE, sel, 1'b1}, a);
        check_bit(a, 1'b1, "read address ack");
        u_sebp_bus_master.recv_byte(1'b1, d);
        check_byte(d, e0, "first read byte");
        u_sebp_bus_master.recv_byte(1'b0, d);
        check_byte(d, e1, "second read byte");
        u_sebp_bus_master.stop_cond();
    endtask

    // ==========================================================================
    // Scenarios
    // ==========================================================================
    // Write across the top byte location and read it back across the wrap.
    task automatic test_readback();
        write_pair(3'h5, 8'hFF, 8'h5A, 8'hC3);
        read_pair(3'h5, 8'hFF, 8'h5A, 8'hC3);
        $display("test readback done");
    endtask

    // Only the select code equal to the straps is acknowledged.
    task automatic test_select();
        logic a;
        for (int s = 0; s < MAX_DEVICES; s++) begin
            u_sebp_bus_master.start_cond();
            u_sebp_bus_master.send_byte({DEV_TYPE, 3'(s), 1'b0}, a);
            check_bit(a, 1'(s == 5), "select ack");
            u_sebp_bus_master.stop_cond();
        end
        $display("test select done");
    endtask

    // A low clock enable freezes the engine: a matching address goes unanswered.
    task automatic test_freeze();
        logic a;
        @(posedge sys_clk);
        clkEnDrv <= 1'b0;
        u_sebp_bus_master.start_cond();
        u_sebp_bus_master.send_byte({DEV_TYPE, 3'h5, 1'b0}, a);
        check_bit(a, 1'b0, "frozen ack");
        u_sebp_bus_master.stop_cond();
        @(posedge sys_clk);
        clkEnDrv <= 1'b1;
        repeat (4) @(posedge sys_clk);
        $display("test freeze done");
    endtask

    // Protected writes are acknowledged yet leave the array unchanged.
    task automatic test_protect();
        @(posedge sys_clk);
        wpDrv <= 1'b1;
        repeat (4) @(posedge sys_clk);
        write_pair(3'h5, 8'hFF, 8'h11, 8'h22);
        read_pair(3'h5, 8'hFF, 8'h5A, 8'hC3);
        $display("test protect done");
    endtask

    // Floating straps read as low: select 0 answers and writes go through.
    task automatic test_float();
        @(posedge sys_clk);
        selDrv <= 3'bzzz;
        wpDrv  <= 1'bz;
        repeat (4) @(posedge sys_clk);
        write_pair(3'h0, 8'h10, 8'h66, 8'h99);
        read_pair(3'h0, 8'h10, 8'h66, 8'h99);
        $display("test float done");
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Main sequence after a 16 cycle reset.
    initial begin
        arst_n = 1'b0;
        selDrv = 3'h5;
        wpDrv  = 1'b0;
        clkEnDrv = 1'b1;
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        test_readback();
        test_select();
        test_freeze();
        test_protect();
        test_float();
        final_report();
    end

    // Watchdog well beyond the expected run of about 50 us.
    initial begin
        #200_000;
        bad_count++;
        $display("ERROR at %0t: watchdog expired", $time);
        final_report();
    end
endmodule // test_sebp_serial_eeprom
